/* src/lfa_map.svh */
// Register offsets, field positions and reset values for the receiver register bank
`ifndef LFA_MAP_SVH
`define LFA_MAP_SVH

// Link register addresses
`define LFA_ADDR_CFG0        4'h0
`define LFA_ADDR_CHSEL       4'h5
`define LFA_ADDR_COLPAR      4'h6
`define LFA_ADDR_STATUS      4'h7
`define LFA_NUM_CFG          4'h7

// Configuration register zero fields
`define LFA_CFG0_ALERT_SRC   4
`define LFA_CFG0_DIS_HI      3
`define LFA_CFG0_DIS_LO      1

// Channel select / gain configuration fields
`define LFA_CHSEL_AUTO       8
`define LFA_CHSEL_AGCGATE    7
`define LFA_CHSEL_MOD_HI     6
`define LFA_CHSEL_MOD_LO     5
`define LFA_CHSEL_SENS_HI    4
`define LFA_CHSEL_SENS_LO    1

// Status register fields
`define LFA_ST_ACT_HI        8
`define LFA_ST_ACT_LO        6
`define LFA_ST_AGC           5
`define LFA_ST_WAKE_HI       4
`define LFA_ST_WAKE_LO       2
`define LFA_ST_ALARM         1
`define LFA_ST_PERR          0

// Reset values
`define LFA_CFG_RESET        9'h000
`define LFA_STATUS_RESET     9'h001

// Modulation depth thresholds in percent, sensitivity step in dB
`define LFA_MOD_SEL0         7'h21
`define LFA_MOD_SEL1         7'h3c
`define LFA_MOD_SEL2         7'h0e
`define LFA_MOD_SEL3         7'h08
`define LFA_SENS_STEP_DB     5'h02

// Controller APB register offsets
`define LFA_APB_CMD          8'h00
`define LFA_APB_WDATA        8'h04
`define LFA_APB_RDATA        8'h08
`define LFA_APB_STAT         8'h0c

// Controller command register fields
`define LFA_CMD_GO           0
`define LFA_CMD_WRITE        1
`define LFA_CMD_SOFTRST      2
`define LFA_CMD_SLEEP        3
`define LFA_CMD_AUTOPAR      4
`define LFA_CMD_ADDR_HI      11
`define LFA_CMD_ADDR_LO      8

`endif

/* src/lfa_pkg.sv */
// Types shared by both ends of the receiver register link
`default_nettype none
package lfa_pkg;

  typedef logic [8:0] lfaWord_t;
  typedef lfaWord_t [6:0] lfaCfgArr_t;

  typedef struct packed {
    lfaCfgArr_t cfg;
    lfaWord_t   status;
    logic [2:0] autoMask;
    logic       settled;
    lfaWord_t   rdata;
    logic       rspValid;
    logic       cfgWritten;
  } lfaDevState_t;

  typedef enum logic [2:0] {
    LFA_IDLE = 3'b001,
    LFA_REQ  = 3'b010,
    LFA_WAIT = 3'b100
  } lfaHostState_t;

  typedef struct packed {
    lfaHostState_t fsm;
    logic [3:0]    addr;
    logic          write;
    logic          autoPar;
    lfaWord_t      wdata;
    lfaWord_t      rdata;
    lfaCfgArr_t    shadow;
    logic          reqValid;
    lfaWord_t      reqWdata;
    logic          softRst;
    logic          sleep;
    logic          done;
  } lfaHostState_s_t;

endpackage : lfa_pkg
`default_nettype wire

/* src/lfa_link_if.sv */
// Register access link between the host controller and the receiver
`timescale 1ns/1ps
`default_nettype none
interface lfa_link_if;
  logic                reqValid;
  logic                reqWrite;
  logic [3:0]          reqAddr;
  lfa_pkg::lfaWord_t   reqWdata;
  logic                rspValid;
  lfa_pkg::lfaWord_t   rspRdata;
  logic                cmdSoftReset;
  logic                cmdSleep;
  logic                alertN;

  modport device (
    input  reqValid, reqWrite, reqAddr, reqWdata, cmdSoftReset, cmdSleep,
    output rspValid, rspRdata, alertN
  );
  modport host (
    output reqValid, reqWrite, reqAddr, reqWdata, cmdSoftReset, cmdSleep,
    input  rspValid, rspRdata, alertN
  );
endinterface : lfa_link_if
`default_nettype wire

/* src/lfa_parity_check.sv */
// Odd row and column parity over the seven configuration registers
`timescale 1ns/1ps
`default_nettype none
module lfa_parity_check (
  input  wire lfa_pkg::lfaCfgArr_t cfg,
  output lfa_pkg::lfaWord_t        expectCol,
  output logic                     parityError
);
  logic [6:0] rowOk;
  logic [8:1] colOk;

  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : gRow
      assign rowOk[g] = ^cfg[g];
    end
    for (g = 1; g < 8; g++) begin : gCol
      // Column bit held at the same position as the data bit it covers
      assign expectCol[g] = ~(cfg[0][g] ^ cfg[1][g] ^ cfg[2][g] ^ cfg[3][g] ^ cfg[4][g]
                              ^ cfg[5][g]); // RQ8
      assign colOk[g] = (cfg[6][g] == expectCol[g]); // RQ23
    end
  endgenerate

  assign expectCol[8] = ~(cfg[0][0] ^ cfg[1][0] ^ cfg[2][0] ^ cfg[3][0] ^ cfg[4][0]
                          ^ cfg[5][0]); // RQ9
  assign expectCol[0] = ~(^expectCol[8:1]); // RQ10
  assign colOk[8]     = (cfg[6][8] == expectCol[8]);
  assign parityError  = ~(&rowOk) | ~(&colOk); // RQ23
endmodule : lfa_parity_check
`default_nettype wire

/* src/lfa_device_end.sv */
// Receiver end: configuration, column parity and status registers
`timescale 1ns/1ps
`default_nettype none
`include "lfa_map.svh"

// Behaviour
// RQ1 - Auto select keeps channels high at settle end
// RQ2 - Manual mode follows register zero disable bits
// RQ3 - Gated output waits for gain regulation
// RQ4 - Ungated output passes any detected signal
// RQ5 - Two-bit field selects modulation depth threshold
// RQ6 - Four-bit field cuts third channel sensitivity
// RQ7 - Host makes register five odd parity
// RQ8 - Host sets column bits for odd columns
// RQ9 - Host sets top column bit over rows
// RQ10 - Host makes column register odd parity
// RQ11 - Active bits high while channel passes data
// RQ12 - Active bits low in standby
// RQ13 - Gain active bit follows regulation live
// RQ14 - Wake bit set when channel woke device
// RQ15 - Alarm flag set, alerts when source allows
// RQ16 - Parity error sets flag, drives alert low
// RQ17 - Power-on clears status except parity flag
// RQ18 - Soft reset clears bits eight through two
// RQ19 - Status read clears alarm; sleep changes nothing
// RQ20 - Status register read-only, no row parity
// RQ21 - Alert source selects parity or alarm too
// RQ22 - Configuration registers readable and writable
// RQ23 - Any failing parity check raises error flag
// RQ24 - Alarm and parity flags sticky until cleared
module lfa_device_end (
  input  wire logic         clk,
  input  wire logic         reset,
  lfa_link_if.device        link,
  input  wire logic [2:0]   demodHigh,
  input  wire logic         gainSettleDone,
  input  wire logic         agcRegulating,
  input  wire logic [2:0]   wakePass,
  input  wire logic         alarmExpired,
  input  wire logic         standby,
  output logic [2:0]        chanEnable,
  output logic [2:0]        demodOut,
  output logic [6:0]        modDepthPct,
  output logic [4:0]        thirdChanCutDb
);
  lfa_pkg::lfaDevState_t q;
  lfa_pkg::lfaDevState_t d;
  lfa_pkg::lfaWord_t     chSel;
  lfa_pkg::lfaWord_t     cfg0;
  logic                  parityError;
  logic                  cfgAddr;
  logic                  readStatus;
  logic                  statusAddr;
  logic [2:0]            passing;
  logic [2:0]            wakeNext;
  logic                  autoChannelSelect;
  logic                  agcGatedOutputEnable;
  logic [1:0]            minModulationDepth;
  logic [3:0]            thirdChannelSensitivityCut;
  logic                  alertSourceSelect;
  logic [2:0]            channelDisable;
  logic                  parityErrorFlag;
  logic                  alarmFlag;

  assign chSel = q.cfg[5];
  assign cfg0  = q.cfg[0];

  // Named fields of the configuration and status words
  assign autoChannelSelect          = chSel[`LFA_CHSEL_AUTO];
  assign agcGatedOutputEnable       = chSel[`LFA_CHSEL_AGCGATE];
  assign minModulationDepth         = chSel[`LFA_CHSEL_MOD_HI:`LFA_CHSEL_MOD_LO];
  assign thirdChannelSensitivityCut = chSel[`LFA_CHSEL_SENS_HI:`LFA_CHSEL_SENS_LO];
  assign alertSourceSelect          = cfg0[`LFA_CFG0_ALERT_SRC];
  assign channelDisable             = cfg0[`LFA_CFG0_DIS_HI:`LFA_CFG0_DIS_LO];
  assign parityErrorFlag            = q.status[`LFA_ST_PERR];
  assign alarmFlag                  = q.status[`LFA_ST_ALARM];

  lfa_parity_check uParity (
    .cfg         (q.cfg),
    .expectCol   (),
    .parityError (parityError)
  );

  // Channel enable selection
  always_comb begin
    if (autoChannelSelect) begin
      chanEnable = q.autoMask; // RQ1
    end else begin
      chanEnable = ~channelDisable; // RQ2
    end
  end

  // Demodulated data gating
  always_comb begin
    if (agcGatedOutputEnable) begin
      demodOut = demodHigh & chanEnable & {3{agcRegulating}}; // RQ3
    end else begin
      demodOut = demodHigh & chanEnable; // RQ4
    end
  end

  // Modulation depth threshold decode
  always_comb begin
    case (minModulationDepth) // RQ5
      2'h0:    modDepthPct = `LFA_MOD_SEL0;
      2'h1:    modDepthPct = `LFA_MOD_SEL1;
      2'h2:    modDepthPct = `LFA_MOD_SEL2;
      2'h3:    modDepthPct = `LFA_MOD_SEL3;
      default: modDepthPct = `LFA_MOD_SEL0;
    endcase
  end

  // Two dB per step, monotonic from zero
  assign thirdChanCutDb = 5'({1'b0, thirdChannelSensitivityCut}
                             * `LFA_SENS_STEP_DB); // RQ6

  // Per-channel data passing and sticky wake flags
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : gChan
      // Passing only once settled and outside standby
      assign passing[ch]  = chanEnable[ch] & q.settled & ~standby; // RQ11 RQ12
      // Wake flag holds until soft reset; a new wake in that cycle wins
      assign wakeNext[ch] = (q.status[`LFA_ST_WAKE_LO + ch] & ~link.cmdSoftReset)
                            | wakePass[ch]; // RQ14 RQ18
    end
  endgenerate

  // Alert is low when any enabled source is pending
  assign link.alertN = ~(parityErrorFlag // RQ16
                         | (alarmFlag & alertSourceSelect)); // RQ21
  assign link.rspValid = q.rspValid;
  assign link.rspRdata = q.rdata;

  always_comb begin
    d            = q;
    d.rspValid   = 1'b0;
    d.cfgWritten = 1'b0;
    cfgAddr      = (link.reqAddr < `LFA_NUM_CFG);
    statusAddr   = (link.reqAddr == `LFA_ADDR_STATUS);
    readStatus   = 1'b0;

    // Register access
    if (link.reqValid) begin
      d.rspValid = 1'b1;
      if (link.reqWrite) begin
        d.rdata = 9'h000;
        if (cfgAddr) begin
          d.cfg[link.reqAddr[2:0]] = link.reqWdata; // RQ22
          d.cfgWritten = 1'b1;
        end
        // Writes to status or unmapped addresses are dropped
      end else if (cfgAddr) begin
        d.rdata = q.cfg[link.reqAddr[2:0]]; // RQ22
      end else if (statusAddr) begin
        d.rdata    = q.status; // RQ20
        readStatus = 1'b1;
      end else begin
        d.rdata = 9'h000;
      end
    end

    // Settle tracking and automatic channel capture
    if (standby || link.cmdSoftReset) begin
      d.settled = 1'b0;
    end else if (gainSettleDone) begin
      d.settled = 1'b1;
    end
    if (gainSettleDone) begin
      d.autoMask = demodHigh; // RQ1
    end

    // Live status bits; sleep touches none of them
    d.status[`LFA_ST_ACT_HI:`LFA_ST_ACT_LO] = passing; // RQ11 RQ12
    d.status[`LFA_ST_AGC] = agcRegulating; // RQ13 RQ3
    if (link.cmdSoftReset) begin
      d.status[`LFA_ST_ACT_HI:`LFA_ST_WAKE_LO] = 7'h00; // RQ18
    end
    d.status[`LFA_ST_WAKE_HI:`LFA_ST_WAKE_LO] = wakeNext; // RQ14

    // Alarm: read clears, expiry in same cycle wins
    if (readStatus) begin
      d.status[`LFA_ST_ALARM] = 1'b0; // RQ19
    end
    if (alarmExpired) begin
      d.status[`LFA_ST_ALARM] = 1'b1; // RQ15 RQ24
    end

    // Parity flag clears only after a write leaves the bank consistent
    if (parityError) begin
      d.status[`LFA_ST_PERR] = 1'b1; // RQ16 RQ24
    end else if (q.cfgWritten) begin
      d.status[`LFA_ST_PERR] = 1'b0;
    end
  end

  // Power-on state: flags clear except the parity flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q.cfg        <= {7{`LFA_CFG_RESET}};
      q.status     <= `LFA_STATUS_RESET; // RQ17
      q.autoMask   <= 3'h0;
      q.settled    <= 1'b0;
      q.rdata      <= 9'h000;
      q.rspValid   <= 1'b0;
      q.cfgWritten <= 1'b0;
    end else begin
      q <= d;
    end
  end
endmodule : lfa_device_end
`default_nettype wire

/* src/lfa_host_end.sv */
// Host controller: APB command registers driving the receiver register link
`timescale 1ns/1ps
`default_nettype none
`include "lfa_map.svh"
module lfa_host_end (
  input  wire logic         clk,
  input  wire logic         reset,
  lfa_link_if.host          link,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr
);
  lfa_pkg::lfaHostState_s_t q;
  lfa_pkg::lfaHostState_s_t d;
  lfa_pkg::lfaWord_t        expectCol;
  lfa_pkg::lfaWord_t        outWord;
  logic                     apbWr;
  logic                     busy;

  lfa_parity_check uParity (
    .cfg         (q.shadow),
    .expectCol   (expectCol),
    .parityError ()
  );

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign apbWr   = psel && penable && pwrite;
  assign busy    = (q.fsm != lfa_pkg::LFA_IDLE);

  assign link.reqValid     = q.reqValid;
  assign link.reqWrite     = q.write;
  assign link.reqAddr      = q.addr;
  assign link.reqWdata     = q.reqWdata;
  assign link.cmdSoftReset = q.softRst;
  assign link.cmdSleep     = q.sleep;

  always_comb begin
    case (paddr)
      `LFA_APB_CMD:   prdata = {20'h00000, q.addr, 3'h0, q.autoPar, 4'h0};
      `LFA_APB_WDATA: prdata = {23'h000000, q.wdata};
      `LFA_APB_RDATA: prdata = {23'h000000, q.rdata};
      `LFA_APB_STAT:  prdata = {29'h00000000, ~link.alertN, q.done, busy};
      default:        prdata = 32'h00000000;
    endcase
  end

  // Word placed on the link, parity filled in when asked
  always_comb begin
    outWord = q.wdata;
    if (q.autoPar) begin
      if (q.addr == `LFA_ADDR_COLPAR) begin
        outWord = expectCol; // RQ8 RQ9 RQ10
      end else if (q.addr < `LFA_ADDR_COLPAR) begin
        outWord = {q.wdata[8:1], ~(^q.wdata[8:1])}; // RQ7
      end
    end
  end

  always_comb begin
    d          = q;
    d.reqValid = 1'b0;
    d.softRst  = 1'b0;
    d.sleep    = 1'b0;

    if (apbWr && paddr == `LFA_APB_WDATA) begin
      d.wdata = pwdata[8:0];
    end
    if (apbWr && paddr == `LFA_APB_CMD) begin
      d.softRst = pwdata[`LFA_CMD_SOFTRST];
      d.sleep   = pwdata[`LFA_CMD_SLEEP];
    end

    case (q.fsm)
      lfa_pkg::LFA_IDLE: begin
        if (apbWr && paddr == `LFA_APB_CMD && pwdata[`LFA_CMD_GO]) begin
          d.addr    = pwdata[`LFA_CMD_ADDR_HI:`LFA_CMD_ADDR_LO];
          d.write   = pwdata[`LFA_CMD_WRITE];
          d.autoPar = pwdata[`LFA_CMD_AUTOPAR];
          d.done    = 1'b0;
          d.fsm     = lfa_pkg::LFA_REQ;
        end
      end
      lfa_pkg::LFA_REQ: begin
        d.reqValid = 1'b1;
        d.reqWdata = outWord;
        if (q.write && q.addr < `LFA_NUM_CFG) begin
          d.shadow[q.addr[2:0]] = outWord; // RQ22
        end
        d.fsm = lfa_pkg::LFA_WAIT;
      end
      lfa_pkg::LFA_WAIT: begin
        if (link.rspValid) begin
          d.rdata = link.rspRdata;
          d.done  = 1'b1;
          d.fsm   = lfa_pkg::LFA_IDLE;
        end
      end
      default: d.fsm = lfa_pkg::LFA_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q.fsm      <= lfa_pkg::LFA_IDLE;
      q.addr     <= 4'h0;
      q.write    <= 1'b0;
      q.autoPar  <= 1'b0;
      q.wdata    <= 9'h000;
      q.rdata    <= 9'h000;
      q.shadow   <= {7{`LFA_CFG_RESET}};
      q.reqValid <= 1'b0;
      q.reqWdata <= 9'h000;
      q.softRst  <= 1'b0;
      q.sleep    <= 1'b0;
      q.done     <= 1'b0;
    end else begin
      q <= d;
    end
  end
endmodule : lfa_host_end
`default_nettype wire

/* sim/lfa_link_monitor.sv */
// Concurrent checks on the receiver register link
`timescale 1ns/1ps
`default_nettype none
module lfa_link_monitor (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              reqValid,
  input wire logic              reqWrite,
  input wire logic [3:0]        reqAddr,
  input wire lfa_pkg::lfaWord_t reqWdata,
  input wire logic              rspValid,
  input wire lfa_pkg::lfaWord_t rspRdata,
  input wire logic              cmdSoftReset,
  input wire logic              cmdSleep,
  input wire logic              alertN
);
  logic stRd_q;
  // Marks the answer slot of a status read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stRd_q <= 1'b0;
    end else begin
      stRd_q <= reqValid && !reqWrite && reqAddr == 4'h7;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_rsp_next; reqValid |=> rspValid; endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("answer missing");
  property p_rsp_cause; rspValid |-> $past(reqValid); endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("stray answer");
  property p_req_pulse; reqValid |=> !reqValid; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request too long");
  property p_wr_zero; rspValid && $past(reqWrite) |-> rspRdata == 9'h000; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer data");
  property p_rdata_hold; !rspValid |-> $stable(rspRdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_perr_alert; stRd_q && rspValid && rspRdata[0] |-> !$past(alertN); endproperty
  a_perr_alert: assert property (p_perr_alert) else $error("alert not low");
  property p_quiet_alert;
    stRd_q && rspValid && rspRdata[1:0] == 2'h0 |-> $past(alertN);
  endproperty
  a_quiet_alert: assert property (p_quiet_alert) else $error("alert without cause");
  property p_reset_perr; $fell(reset) |-> !alertN; endproperty
  a_reset_perr: assert property (p_reset_perr) else $error("no alert after reset");
  c_auto: cover property (reqValid && reqWrite && reqWdata[8]);
  c_sleep: cover property (cmdSleep);
  c_srst: cover property (cmdSoftReset);
  c_alert: cover property ($fell(alertN));
endmodule : lfa_link_monitor
`default_nettype wire

/* sim/tb_top.sv */
// Bench joining host and receiver ends over one link
`timescale 1ns/1ps
`default_nettype none
`include "lfa_map.svh"
module tb_top;
  localparam logic [2:0] AP = 3'h4;
  localparam logic [2:0] SL = 3'h2;
  localparam logic [2:0] SR = 3'h1;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready;
  logic        pslverr;
  logic        settle = 1'b0;
  logic        agcReg = 1'b0;
  logic        alarmExp = 1'b0;
  logic        stby = 1'b0;
  logic [2:0]  demod = 3'h0;
  logic [2:0]  wake = 3'h0;
  logic [2:0]  chEn;
  logic [2:0]  dOut;
  logic [6:0]  modPct;
  logic [4:0]  cutDb;
  logic [8:0]  v [6];
  logic [8:0]  q;
  logic [6:0]  pct [4] = '{7'h21, 7'h3c, 7'h0e, 7'h08};
  int          n_errors = 0;
  int          n_compared = 0;
  lfa_link_if  lnk ();
  lfa_host_end lfa_host_end_inst (.clk(clk), .reset(reset), .link(lnk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  lfa_device_end lfa_device_end_inst (.clk(clk), .reset(reset), .link(lnk),
    .demodHigh(demod), .gainSettleDone(settle), .agcRegulating(agcReg), .wakePass(wake),
    .alarmExpired(alarmExp), .standby(stby), .chanEnable(chEn), .demodOut(dOut),
    .modDepthPct(modPct), .thirdChanCutDb(cutDb));
  lfa_link_monitor lfa_link_monitor_inst (.clk(clk), .reset(reset),
    .reqValid(lnk.reqValid), .reqWrite(lnk.reqWrite), .reqAddr(lnk.reqAddr),
    .reqWdata(lnk.reqWdata), .rspValid(lnk.rspValid), .rspRdata(lnk.rspRdata),
    .cmdSoftReset(lnk.cmdSoftReset), .cmdSleep(lnk.cmdSleep), .alertN(lnk.alertN));
  always #25 clk = ~clk;
  task automatic conclude();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] o);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      n_errors++;
      conclude();
    end
    o = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // One link transfer through the controller registers
  task automatic link(input logic w, input logic [3:0] a, input logic [8:0] d,
                      input logic [2:0] f, output logic [8:0] o);
    int k;
    apb(1'b1, `LFA_APB_WDATA, {23'h0, d}, r);
    apb(1'b1, `LFA_APB_CMD, {20'h0, a, 3'h0, f, w, 1'b1}, r);
    for (k = 0; k < 50; k++) begin
      apb(1'b0, `LFA_APB_STAT, 32'h0, r);
      if (r[0] === 1'b0) break;
    end
    if (k == 50) begin
      n_errors++;
      conclude();
    end
    apb(1'b0, `LFA_APB_RDATA, 32'h0, r);
    o = r[8:0];
  endtask : link
  task automatic rdc(input logic [3:0] a, input logic [8:0] e, input logic [8:0] m);
    link(1'b0, a, 9'h000, 3'h0, q);
    chk({23'h0, q & m}, {23'h0, e & m});
  endtask : rdc
  function automatic logic [8:0] odd(input logic [8:0] x);
    return {x[8:1], ~^x[8:1]};
  endfunction : odd
  function automatic logic [8:0] colp();
    logic [8:0] c;
    c = 9'h1fe;
    for (int i = 0; i < 6; i++) c = c ^ {v[i][0], v[i][7:1], 1'b0};
    return odd(c);
  endfunction : colp
  task automatic put(input logic [3:0] a, input logic [8:0] d);
    v[a] = odd(d);
    link(1'b1, a, d, AP, q);
    rdc(a, v[a], 9'h1ff);
  endtask : put
  task automatic pulse(input logic [2:0] wk, input logic al, input logic st);
    wake <= wk;
    alarmExp <= al;
    settle <= st;
    @(posedge clk);
    wake <= 3'h0;
    alarmExp <= 1'b0;
    settle <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  initial begin
    for (int i = 0; i < 6; i++) v[i] = 9'h000;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(4'h7, 9'h001, 9'h1ff);
    chk({31'h0, lnk.alertN}, 32'h0);
    apb(1'b0, `LFA_APB_STAT, 32'h0, r);
    chk(r, 32'h6);
    rdc(4'h6, 9'h000, 9'h1ff);
    apb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    put(4'h0, 9'h010);
    put(4'h1, 9'h0a4);
    put(4'h2, 9'h133);
    put(4'h3, 9'h07e);
    put(4'h4, 9'h15a);
    for (int m = 0; m < 4; m++) begin
      put(4'h5, {2'h0, 2'(m), 4'(5 * m), 1'b0});
      chk({25'h0, modPct}, {25'h0, pct[m]});
      chk({27'h0, cutDb}, 32'(10 * m));
    end
    link(1'b1, 4'h6, 9'h000, AP, q);
    rdc(4'h6, colp(), 9'h1ff);
    rdc(4'h7, 9'h000, 9'h003);
    put(4'h0, 9'h014);
    chk({29'h0, chEn}, 32'h5);
    put(4'h0, 9'h010);
    put(4'h5, 9'h180);
    link(1'b1, 4'h6, 9'h000, AP, q);
    demod <= 3'h6;
    pulse(3'h0, 1'b0, 1'b1);
    chk({29'h0, chEn}, 32'h6);
    chk({29'h0, dOut}, 32'h0);
    agcReg <= 1'b1;
    repeat (2) @(posedge clk);
    chk({29'h0, dOut}, 32'h6);
    rdc(4'h7, 9'h1a0, 9'h1e0);
    put(4'h5, 9'h100);
    agcReg <= 1'b0;
    link(1'b1, 4'h6, 9'h000, AP, q);
    chk({29'h0, dOut}, 32'h6);
    stby <= 1'b1;
    rdc(4'h7, 9'h000, 9'h1e0);
    stby <= 1'b0;
    pulse(3'h5, 1'b1, 1'b0);
    chk({31'h0, lnk.alertN}, 32'h0);
    rdc(4'h7, 9'h016, 9'h01f);
    rdc(4'h7, 9'h014, 9'h01f);
    chk({31'h0, lnk.alertN}, 32'h1);
    pulse(3'h0, 1'b1, 1'b0);
    link(1'b0, 4'h5, 9'h000, SL, q);
    rdc(4'h7, 9'h016, 9'h01f);
    pulse(3'h0, 1'b1, 1'b0);
    link(1'b0, 4'h5, 9'h000, SR, q);
    rdc(4'h7, 9'h002, 9'h1ff);
    put(4'h0, 9'h000);
    link(1'b1, 4'h6, 9'h000, AP, q);
    pulse(3'h0, 1'b1, 1'b0);
    chk({31'h0, lnk.alertN}, 32'h1);
    rdc(4'h7, 9'h002, 9'h003);
    link(1'b1, 4'h1, 9'h003, 3'h0, q);
    chk({31'h0, lnk.alertN}, 32'h0);
    link(1'b1, 4'h7, 9'h1fe, 3'h0, q);
    rdc(4'h7, 9'h001, 9'h1ff);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(4'h1, 9'h000, 9'h1ff);
    rdc(4'h7, 9'h001, 9'h1ff);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
